/* File: verilog/hotswap_pkg.sv */
package hotswap_pkg;

  // register offsets
  localparam logic [7:0] OFF_HV_A_CFG = 8'h02;
  localparam logic [7:0] OFF_LV_A_CFG = 8'h03;
  localparam logic [7:0] OFF_HV_B_CFG = 8'h04;
  localparam logic [7:0] OFF_LV_B_CFG = 8'h05;
  localparam logic [7:0] OFF_SYS_CFG = 8'h06;
  localparam logic [7:0] OFF_PWR_EV = 8'h07;
  localparam logic [7:0] OFF_OC_EV = 8'h08;
  localparam logic [7:0] OFF_LIVE = 8'h09;

  // channel configuration fields
  localparam int CFG_ENABLE_BIT = 5;
  localparam int CFG_BLEED_WAIT = 6;
  // system configuration fields
  localparam int SYS_SLOT_A_MASK = 5;
  localparam int SYS_SLOT_B_MASK = 6;
  localparam int SYS_CROSS_DIS = 7;

  // reset values
  localparam logic [7:0] RST_CHAN_CFG = 8'h01;
  localparam logic [7:0] RST_SYS_CFG = 8'h00;
  localparam logic [7:0] RST_PWR_EV = 8'h55;
  localparam logic [7:0] RST_OC_EV = 8'h00;

  // serial bus address, arbitrary value
  localparam logic [6:0] DEV_ADDR = 7'h2C;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_RD_BIT = 4'h7;
  // cycles after reset before channels may turn on
  localparam logic [1:0] STARTUP_CYC = 2'h3;
  localparam int NUM_CH = 4;

  // per-channel comparator levels; channel order hv_a, lv_a, hv_b, lv_b
  typedef struct packed {
    logic pgood;
    logic timer_out;
    logic in_limit;
    logic fast_trip;
    logic out_low;
  } chan_in_s;

  // per-slot levels from the analog ORing and gate comparators
  typedef struct packed {
    logic block_cmd;
    logic pass_above;
    logic oring_on;
    logic gate_on;
    logic enable_pin;
  } slot_in_s;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR = 7'h08,
    ST_WACK = 7'h10,
    ST_RD = 7'h20,
    ST_RACK = 7'h40
  } bus_state_e;

endpackage : hotswap_pkg

/* File: verilog/level_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // two flops per bit; the first is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : level_sync
`default_nettype wire

/* File: verilog/hotswap_status_enable_logic.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - cross link on: low-voltage fault also switches off its high-voltage partner
// - cross link disabled: high-voltage channels ignore low-voltage faults
// - pgood-lost bits set at reset and on pgood fall; read clears if good
// - timeout bits set on timer expiry, held until power event register read
// - power events: pgood-lost even, timeout odd, per channel hv_a lv_a hv_b lv_b
// - unmasked slot A bits 3:0 or slot B bits 7:4 assert alert
// - in-limit bit latches on current limit, held until overcurrent register read
// - fast-trip bit latches on fast trip, held until overcurrent register read
// - overcurrent events: in-limit even, fast-trip odd, all reset zero
// - live bits 0 and 3 high when slot block drive commanded
// - live bits 1 and 4 low when pass gate above timer start
// - live bits 2 and 5 low when low-voltage ORing commands pass on
// - live bits 6 and 7 low when low-voltage gate driven on
// - all drives held low and low-voltage channels off during startup
// - power-on reset loads every register with its default
// - low-voltage channel on only while its enable pin is high
// - every channel on only while its register enable bit is set
// - bleed wait set: channel turns on only once output is low
// - cross link on: high-voltage needs partner pgood, off when lost
// - system config: slot A mask bit 5, slot B mask bit 6
// - clearing high-voltage enable drops both pass and block drives
module hotswap_status_enable_logic (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire hotswap_pkg::chan_in_s [3:0] chan_in,
  input wire hotswap_pkg::slot_in_s [1:0] slot_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic alert_out_n,
  output logic hv_a_pass_drive,
  output logic hv_a_block_drive,
  output logic hv_b_pass_drive,
  output logic hv_b_block_drive,
  output logic lv_a_gate_drive,
  output logic lv_b_gate_drive
);
  import hotswap_pkg::*;

  chan_in_s [3:0] chan_s;
  slot_in_s [1:0] slot_s;
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic [1:0] boot_cnt_r;
  logic ready;
  logic [3:0] pg_prev_r;
  logic [7:0] pwr_ev_r;
  logic [7:0] pwr_ev_nxt;
  logic [7:0] oc_ev_r;
  logic [7:0] oc_ev_nxt;
  logic [7:0] clr_pwr_r;
  logic [7:0] clr_oc_r;
  logic [7:0] cfg_r [NUM_CH];
  logic [7:0] sys_r;
  logic [3:0] on_r;
  logic [3:0] on_nxt;
  logic [3:0] base_ok;
  logic [1:0] cross_ok;
  logic [1:0] blk_r;
  logic [7:0] live;
  logic alert_nxt;
  bus_state_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic ptr_phase_r;
  logic rw_r;
  logic acked_r;
  logic wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic load_c;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  level_sync #(.W(32)) i_level_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in({chan_in, slot_in, scl_in, sda_in}),
    .sync_out({chan_s, slot_s, scl_s, sda_s})
  );

  // register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    case (p)
      OFF_HV_A_CFG: v = cfg_r[0];
      OFF_LV_A_CFG: v = cfg_r[1];
      OFF_HV_B_CFG: v = cfg_r[2];
      OFF_LV_B_CFG: v = cfg_r[3];
      OFF_SYS_CFG: v = sys_r;
      OFF_PWR_EV: v = pwr_ev_r;
      OFF_OC_EV: v = oc_ev_r;
      OFF_LIVE: v = live;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // startup hold

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r <= 2'h0;
    end else if (ce && !ready) begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
    end
  end
  assign ready = (boot_cnt_r == STARTUP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // latched events

  // set terms win over the read clear mask
  always_comb begin
    pwr_ev_nxt = pwr_ev_r;
    oc_ev_nxt = oc_ev_r;
    for (int c = 0; c < NUM_CH; c++) begin
      if (clr_pwr_r[2*c] && chan_s[c].pgood) begin
        pwr_ev_nxt[2*c] = 1'b0;
      end
      if (pg_prev_r[c] && !chan_s[c].pgood) begin
        pwr_ev_nxt[2*c] = 1'b1;
      end
      pwr_ev_nxt[2*c+1] = (pwr_ev_r[2*c+1] & ~clr_pwr_r[2*c+1]) | chan_s[c].timer_out;
      oc_ev_nxt[2*c] = (oc_ev_r[2*c] & ~clr_oc_r[2*c]) | chan_s[c].in_limit;
      oc_ev_nxt[2*c+1] = (oc_ev_r[2*c+1] & ~clr_oc_r[2*c+1]) | chan_s[c].fast_trip;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ev_r <= RST_PWR_EV;
      oc_ev_r <= RST_OC_EV;
      pg_prev_r <= 4'h0;
    end else if (ce) begin
      pwr_ev_r <= pwr_ev_nxt;
      oc_ev_r <= oc_ev_nxt;
      pg_prev_r <= {chan_s[3].pgood, chan_s[2].pgood, chan_s[1].pgood, chan_s[0].pgood};
    end
  end

  assign alert_nxt = ~(((|pwr_ev_r[3:0]) & ~sys_r[SYS_SLOT_A_MASK])
                       | ((|pwr_ev_r[7:4]) & ~sys_r[SYS_SLOT_B_MASK]));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_out_n <= 1'b1;
    end else if (ce) begin
      alert_out_n <= alert_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_r[c] <= RST_CHAN_CFG;
      end
      sys_r <= RST_SYS_CFG;
    end else if (ce && wr_stb_r) begin
      if (wr_addr_r == OFF_SYS_CFG) begin
        sys_r <= wr_data_r;
      end else if (wr_addr_r >= OFF_HV_A_CFG && wr_addr_r <= OFF_LV_B_CFG) begin
        cfg_r[2'(wr_addr_r - OFF_HV_A_CFG)] <= wr_data_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel enable qualification

  assign cross_ok[0] = sys_r[SYS_CROSS_DIS] | (chan_s[1].pgood & ~chan_s[1].timer_out);
  assign cross_ok[1] = sys_r[SYS_CROSS_DIS] | (chan_s[3].pgood & ~chan_s[3].timer_out);

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      base_ok[c] = cfg_r[c][CFG_ENABLE_BIT];
    end
    base_ok[0] = base_ok[0] & cross_ok[0];
    base_ok[2] = base_ok[2] & cross_ok[1];
    base_ok[1] = base_ok[1] & slot_s[0].enable_pin;
    base_ok[3] = base_ok[3] & slot_s[1].enable_pin;
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!ready || !base_ok[c]) begin
        on_nxt[c] = 1'b0;
      end else begin
        on_nxt[c] = on_r[c] | ~cfg_r[c][CFG_BLEED_WAIT] | chan_s[c].out_low;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_r <= 4'h0;
      blk_r <= 2'h0;
    end else if (ce) begin
      on_r <= on_nxt;
      blk_r <= {on_nxt[2] & slot_s[1].block_cmd, on_nxt[0] & slot_s[0].block_cmd};
    end
  end

  assign hv_a_pass_drive = on_r[0];
  assign lv_a_gate_drive = on_r[1];
  assign hv_b_pass_drive = on_r[2];
  assign lv_b_gate_drive = on_r[3];
  assign hv_a_block_drive = blk_r[0];
  assign hv_b_block_drive = blk_r[1];

  assign live = {~slot_s[1].gate_on, ~slot_s[0].gate_on, ~slot_s[1].oring_on,
                 ~slot_s[1].pass_above, blk_r[1], ~slot_s[0].oring_on,
                 ~slot_s[0].pass_above, blk_r[0]};

  ////////////////////////////////////////////////////////////////////////////
  // two-wire serial slave

  assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign load_c = scl_fall & ~start_c & ~stop_c
                  & (((st_r == ST_AACK) & rw_r) | ((st_r == ST_RACK) & acked_r));
  // a process, so register contents reach the read mux as they change
  always_comb rd_byte = reg_read(ptr_r);

  // edge history; resets low like the synchronisers, so no false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // byte engine: address, pointer, writes and reads with auto increment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      ptr_phase_r <= 1'b0;
      rw_r <= 1'b0;
      acked_r <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      clr_pwr_r <= 8'h00;
      clr_oc_r <= 8'h00;
    end else if (ce) begin
      wr_stb_r <= 1'b0;
      clr_pwr_r <= 8'h00;
      clr_oc_r <= 8'h00;
      if (start_c) begin
        st_r <= ST_ADDR;
        cnt_r <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        st_r <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (st_r == ST_ADDR || st_r == ST_WR) begin
          sh_r <= {sh_r[6:0], sda_s};
          cnt_r <= cnt_r + 4'h1;
        end else if (st_r == ST_RACK) begin
          acked_r <= ~sda_s;
        end
      end else if (load_c) begin
        // clear only what this byte captured
        st_r <= ST_RD;
        sh_r <= rd_byte;
        sda_oe_n <= rd_byte[7];
        cnt_r <= 4'h0;
        ptr_r <= ptr_r + 8'h01;
        clr_pwr_r <= (ptr_r == OFF_PWR_EV) ? rd_byte : 8'h00;
        clr_oc_r <= (ptr_r == OFF_OC_EV) ? rd_byte : 8'h00;
      end else if (scl_fall) begin
        case (st_r)
          ST_ADDR: begin
            if (cnt_r == BYTE_BITS) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                st_r <= ST_AACK;
                rw_r <= sh_r[0];
                sda_oe_n <= 1'b0;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            st_r <= ST_WR;
            sda_oe_n <= 1'b1;
            cnt_r <= 4'h0;
            ptr_phase_r <= 1'b1;
          end
          ST_WR: begin
            if (cnt_r == BYTE_BITS) begin
              st_r <= ST_WACK;
              sda_oe_n <= 1'b0;
              ptr_phase_r <= 1'b0;
              if (ptr_phase_r) begin
                ptr_r <= sh_r;
              end else begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= sh_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_WACK: begin
            st_r <= ST_WR;
            sda_oe_n <= 1'b1;
            cnt_r <= 4'h0;
          end
          ST_RD: begin
            if (cnt_r == LAST_RD_BIT) begin
              st_r <= ST_RACK;
              sda_oe_n <= 1'b1;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              sda_oe_n <= sh_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
          ST_RACK: st_r <= ST_IDLE;
          ST_IDLE: st_r <= ST_IDLE;
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence pg_fall_s;
    ce && pg_prev_r[0] && !chan_s[0].pgood;
  endsequence

  chk_cross_off: assert property (
    ce && !sys_r[SYS_CROSS_DIS] && !chan_s[1].pgood |=> !hv_a_pass_drive && !hv_a_block_drive)
    else $error("hv_a stayed on after partner lost pgood");
  chk_cross_keep: assert property (
    ce && sys_r[SYS_CROSS_DIS] && hv_a_pass_drive && cfg_r[0][CFG_ENABLE_BIT] && ready
    |=> hv_a_pass_drive)
    else $error("hv_a dropped despite cross link disabled");
  chk_pg_latch: assert property (
    pg_fall_s |=> pwr_ev_r[0])
    else $error("pgood loss not latched");
  chk_timeout_hold: assert property (
    ce && pwr_ev_r[1] && !clr_pwr_r[1] |=> pwr_ev_r[1])
    else $error("timeout bit dropped without a read");
  chk_alert_level: assert property (
    ce && pwr_ev_r[3] && !sys_r[SYS_SLOT_A_MASK] |=> !alert_out_n)
    else $error("alert not asserted for unmasked event");
  chk_oc_latch: assert property (
    ce && chan_s[2].in_limit |=> oc_ev_r[4] ##1 (oc_ev_r[4] || !ce || $past(clr_oc_r[4])))
    else $error("in-limit bit not latched");
  chk_trip_latch: assert property (
    ce && chan_s[3].fast_trip |=> oc_ev_r[7])
    else $error("fast trip not latched");
  chk_enable_bit: assert property (
    ce && !cfg_r[2][CFG_ENABLE_BIT] |=> !hv_b_pass_drive && !hv_b_block_drive)
    else $error("hv_b on with enable bit clear");
  chk_bleed_wait: assert property (
    ce && !on_r[2] && cfg_r[2][CFG_BLEED_WAIT] && !chan_s[2].out_low |=> !hv_b_pass_drive)
    else $error("hv_b turned on before bleed down");
  chk_pin_gate: assert property (
    ce && !slot_s[1].enable_pin |=> !lv_b_gate_drive)
    else $error("lv_b on with enable pin low");

endmodule : hotswap_status_enable_logic
`default_nettype wire

/* File: tb/i2c_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
  import hotswap_pkg::*;
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  int ack_err;

  // scl driven high and sda released while idle; the wire pull-up gives the sda high level
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    ack_err = 0;
  end

  // wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // one bit: data set while scl low, line sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    tick(6);
    scl = 1'b1;
    tick(6);
    s = sda;
    scl = 1'b0;
    tick(2);
  endtask : bit_io

  // start, also serves as repeated start
  task automatic start_c();
    sda_rel = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_rel = 1'b0;
    tick(6);
    scl = 1'b0;
    tick(2);
  endtask : start_c

  task automatic stop_c();
    sda_rel = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_rel = 1'b1;
    tick(6);
  endtask : stop_c

  // byte out, msb first; a missing acknowledge is counted
  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    if (s !== 1'b0) begin
      ack_err++;
    end
  endtask : wbyte

  // byte in; ack low asks for another byte, high ends the read
  task automatic rbyte(input logic ack, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, q[i]);
    end
    bit_io(ack, s);
  endtask : rbyte

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start_c();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(p);
    wbyte(d);
    stop_c();
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    start_c();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(p);
    start_c();
    wbyte({DEV_ADDR, 1'b1});
    rbyte(1'b1, q);
    stop_c();
  endtask : rd

  // two-byte read, pointer advances between the bytes
  task automatic rd2(input logic [7:0] p, output logic [7:0] q0, output logic [7:0] q1);
    start_c();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(p);
    start_c();
    wbyte({DEV_ADDR, 1'b1});
    rbyte(1'b0, q0);
    rbyte(1'b1, q1);
    stop_c();
  endtask : rd2
endmodule : i2c_host_model
`default_nettype wire

/* File: tb/tb_hotswap_status_enable_logic.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_hotswap_status_enable_logic;
  import hotswap_pkg::*;
  logic clk;
  logic rst_n;
  chan_in_s [3:0] chan_in;
  slot_in_s [1:0] slot_in;
  logic scl;
  logic sda_rel;
  logic sda_out;
  logic sda_oe_n;
  logic sda;
  logic alert_out_n;
  logic hv_a_pass_drive;
  logic hv_a_block_drive;
  logic hv_b_pass_drive;
  logic hv_b_block_drive;
  logic lv_a_gate_drive;
  logic lv_b_gate_drive;
  int n_errors;
  int samples_checked;
  int cyc;
  logic [7:0] q;
  logic [7:0] q1;
  logic ce;

  // 250 MHz clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // wired-and data line with pull-up
  assign sda = sda_rel & (sda_oe_n | sda_out);

  hotswap_status_enable_logic i_hotswap_status_enable_logic (
    .clk(clk), .rst_n(rst_n), .ce(ce), .chan_in(chan_in), .slot_in(slot_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .alert_out_n(alert_out_n), .hv_a_pass_drive(hv_a_pass_drive),
    .hv_a_block_drive(hv_a_block_drive), .hv_b_pass_drive(hv_b_pass_drive),
    .hv_b_block_drive(hv_b_block_drive), .lv_a_gate_drive(lv_a_gate_drive),
    .lv_b_gate_drive(lv_b_gate_drive)
  );

  i2c_host_model i_host (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] drv();
    return {2'h0, hv_a_pass_drive, hv_a_block_drive, hv_b_pass_drive,
            hv_b_block_drive, lv_a_gate_drive, lv_b_gate_drive};
  endfunction : drv

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] p, input logic [7:0] e, input string nm);
    i_host.rd(p, q);
    chk(nm, e, q);
  endtask : rdchk

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    tick(2);
    chk("alert after reset", 8'h00, {7'h00, alert_out_n});
    chk("drives in startup", 8'h00, drv());
    rdchk(OFF_PWR_EV, 8'h55, "power events default");
    rdchk(OFF_PWR_EV, 8'h00, "power events cleared");
    chk("alert released", 8'h01, {7'h00, alert_out_n});
    rdchk(OFF_OC_EV, 8'h00, "overcurrent default");
    rdchk(OFF_SYS_CFG, 8'h00, "sys cfg default");
    rdchk(OFF_HV_A_CFG, 8'h01, "chan cfg default");
    rdchk(8'h0A, 8'h00, "unmapped offset");
  endtask : t_reset

  task automatic t_events();
    for (int c = 0; c < 4; c++) begin
      chan_in[c].pgood = 1'b0;
      chan_in[c].timer_out = 1'b1;
      tick(6);
      chan_in[c].timer_out = 1'b0;
      chk("alert on event", 8'h00, {7'h00, alert_out_n});
      rdchk(OFF_PWR_EV, 8'h03 << (2 * c), "pgood and timeout");
      chan_in[c].pgood = 1'b1;
      rdchk(OFF_PWR_EV, 8'h01 << (2 * c), "pgood kept while low");
      rdchk(OFF_PWR_EV, 8'h00, "power events clear");
      chk("alert idle", 8'h01, {7'h00, alert_out_n});
      chan_in[c].in_limit = 1'b1;
      tick(6);
      rdchk(OFF_OC_EV, 8'h01 << (2 * c), "in limit");
      chan_in[c].in_limit = 1'b0;
      rdchk(OFF_OC_EV, 8'h01 << (2 * c), "event during read kept");
      chan_in[c].fast_trip = 1'b1;
      tick(6);
      chan_in[c].fast_trip = 1'b0;
      rdchk(OFF_OC_EV, 8'h02 << (2 * c), "fast trip");
    end
  endtask : t_events

  task automatic t_mask();
    for (int s = 0; s < 2; s++) begin
      i_host.wr(OFF_SYS_CFG, 8'h20 << s);
      chan_in[2 * s].timer_out = 1'b1;
      tick(6);
      chan_in[2 * s].timer_out = 1'b0;
      chk("alert masked", 8'h01, {7'h00, alert_out_n});
      chan_in[2 - 2 * s].timer_out = 1'b1;
      tick(6);
      chan_in[2 - 2 * s].timer_out = 1'b0;
      chk("alert unmasked", 8'h00, {7'h00, alert_out_n});
      rdchk(OFF_PWR_EV, 8'h22, "both timeouts");
      chk("alert after read", 8'h01, {7'h00, alert_out_n});
    end
    i_host.wr(OFF_SYS_CFG, 8'h00);
  endtask : t_mask

  task automatic t_enable();
    for (int p = 2; p < 6; p++) begin
      i_host.wr(8'(p), 8'h21);
    end
    tick(6);
    chk("all enabled", 8'h3F, drv());
    slot_in[0].enable_pin = 1'b0;
    tick(6);
    chk("lv pin low", 8'h3D, drv());
    slot_in[0].enable_pin = 1'b1;
    chan_in[1].timer_out = 1'b1;
    tick(6);
    chk("cross link fault", 8'h0C, drv() & 8'h3C);
    i_host.wr(OFF_SYS_CFG, 8'h80);
    tick(6);
    chk("cross link disabled", 8'h3C, drv() & 8'h3C);
    chan_in[1].timer_out = 1'b0;
    chan_in[1].pgood = 1'b0;
    tick(6);
    chk("pgood lost, unlinked", 8'h3C, drv() & 8'h3C);
    i_host.wr(OFF_SYS_CFG, 8'h00);
    tick(6);
    chk("pgood lost, linked", 8'h0C, drv() & 8'h3C);
    chan_in[1].pgood = 1'b1;
    tick(6);
    chk("partner pgood back", 8'h3C, drv() & 8'h3C);
    i_host.wr(OFF_HV_A_CFG, 8'h01);
    tick(6);
    chk("hv a disabled", 8'h0C, drv() & 8'h3C);
  endtask : t_enable

  task automatic t_bleed();
    i_host.wr(OFF_HV_B_CFG, 8'h01);
    i_host.wr(OFF_HV_B_CFG, 8'h61);
    tick(6);
    chk("bleed wait holds", 8'h00, drv() & 8'h0C);
    chan_in[2].out_low = 1'b1;
    tick(6);
    chk("bleed done", 8'h0C, drv() & 8'h0C);
    chan_in[2].out_low = 1'b0;
    tick(6);
    chk("stays on", 8'h0C, drv() & 8'h0C);
  endtask : t_bleed

  task automatic t_live();
    slot_in[0] = 5'b11011;
    slot_in[1] = 5'b10101;
    rdchk(OFF_LIVE, 8'h9C, "live pattern one");
    slot_in[0] = 5'b10101;
    slot_in[1] = 5'b11011;
    rdchk(OFF_LIVE, 8'h6A, "live pattern two");
  endtask : t_live

  // clock enable freeze, two-byte read, then a reset in mid-run
  task automatic t_freeze();
    ce = 1'b0;
    slot_in[1].enable_pin = 1'b0;
    tick(6);
    chk("held while ce low", 8'h01, drv() & 8'h01);
    ce = 1'b1;
    tick(6);
    chk("lv b pin low", 8'h00, drv() & 8'h01);
    slot_in[1].enable_pin = 1'b1;
    i_host.rd2(OFF_HV_A_CFG, q, q1);
    chk("burst byte one", 8'h01, q);
    chk("burst byte two", 8'h21, q1);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(2);
    chk("drives after reset", 8'h00, drv());
    rdchk(OFF_HV_B_CFG, 8'h01, "cfg reloaded");
    rdchk(OFF_PWR_EV, 8'h55, "events reloaded");
  endtask : t_freeze

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    chan_in = {4{5'b10000}};
    slot_in = {2{5'b10001}};
    cyc = 0;
    n_errors = 0;
    samples_checked = 0;
    tick(20);
    rst_n = 1'b1;
    t_reset();
    t_events();
    t_mask();
    t_enable();
    t_bleed();
    t_live();
    t_freeze();
    chk("missing acks", 8'h00, 8'(i_host.ack_err));
    end_sim();
  end
endmodule : tb_hotswap_status_enable_logic
`default_nettype wire
